// ---- touch_pkg.sv ----
// shared constants for the touch controller command link
package touch_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h63;
	localparam logic [7:0] CMD_RD_POWER = 8'h18;
	localparam logic [7:0] CMD_WR_POWER = 8'h19;
	localparam logic [7:0] CMD_RD_IRQ = 8'hA2;
	localparam logic [7:0] CMD_WR_IRQ = 8'hA4;
	localparam logic [7:0] CMD_RD_FW = 8'hA6;
	localparam logic [7:0] CMD_RD_ID = 8'hA8;
	localparam logic [7:0] MODE_ZERO = 8'h00;
	localparam logic [7:0] MODE_ONE = 8'h01;
	localparam int CLK_HZ = 10000000;
	localparam int PULSE_US = 50;
	localparam int PULSE_CYC = (PULSE_US * (CLK_HZ / 1000000) > 0) ?
		PULSE_US * (CLK_HZ / 1000000) : 1;
	localparam int GAP_US = 100;
	localparam int GAP_CYC = GAP_US * (CLK_HZ / 1000000);
	localparam int POWER_WAIT_MS = 15;
	localparam int POWER_WAIT_CYC = POWER_WAIT_MS * (CLK_HZ / 1000);
	localparam int HALF_SCL = 10;
	// host register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	localparam int CTRL_GO = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_TWO = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_NACK = 1;
	localparam int IRQ_TOUCH = 2;
	localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
endpackage

// ---- touch_link_if.sv ----
// i2c link and interrupt line joining host and touch device
interface touch_link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic int_n;
	logic scl;
	logic sda;
	// open drain resolution
	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o) ? 1'b0 : 1'b1;
	modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe, output int_n);
	modport host (input scl, input sda, output scl_o, output scl_oe, output sda_host_o,
		output sda_host_oe, input int_n);
endinterface

// ---- touch_irq_gen.sv ----
// interrupt pin generator: level or pulsed per report interval
module touch_irq_gen
	import touch_pkg::*;
#(
	parameter int REPORT_CYC = 100000
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic pulsed,
	input wire logic touch,
	// pin
	output logic int_n
);
	logic [31:0] cnt, next_cnt;
	logic next_int_n;
	always_comb
	begin
		next_cnt = 32'h0;
		next_int_n = 1'b1;
		if (touch && !pulsed)
			next_int_n = 1'b0;
		else if (touch)
		begin
			next_cnt = (cnt >= 32'(REPORT_CYC - 1)) ? 32'h0 : cnt + 32'h1;
			// low while the interval counter is in its first stretch; a drop of touch clears the counter and ends a pulse at once
			next_int_n = !(cnt < 32'(PULSE_CYC));
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 32'h0;
			int_n <= 1'b1;
		end
		else
		begin
			cnt <= next_cnt;
			int_n <= next_int_n;
		end
	end
endmodule

// ---- touch_dev.sv ----
// touch controller i2c slave command interpreter
// Contract
// - command 18 returns power mode byte
// - power mode 0 active, 1 idle
// - write 19 plus byte sets power
// - host waits 15 ms before power read; touch_host has no such wait
// - command A2 returns interrupt mode byte
// - host stops, waits 100 us, rereads
// - interrupt mode 0 level, 1 pulsed
// - level mode holds int low while touched
// - pulsed mode 50 us low per interval
// - write A4 plus byte sets interrupt mode
// - interrupt mode kept across power-on reset
// - command A6 returns firmware version
// - command A8 returns id, msb first
// - slave only at address 63, 400k
// - host ends with stop, no restart
module touch_dev
	import touch_pkg::*;
#(
	parameter logic [7:0] FW_VERSION = 8'h01, // arbitrary
	parameter logic [15:0] CHIP_ID = 16'h5A5A, // arbitrary
	parameter int REPORT_CYC = 100000
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sensing side
	input wire logic touch,
	// nonvolatile store of the interrupt mode
	input wire logic nv_irq_mode,
	output logic nv_wr,
	output logic nv_wdata,
	// status
	output logic power_mode,
	output logic irq_mode,
	// link
	touch_link_if.dev link
);
	typedef enum {S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_DATA, S_DACK, S_TX, S_TACK,
		S_SKIP} state_t;
	state_t st, next_st;
	logic [2:0] scl_s, sda_s;
	logic scl, sda, scl_r, scl_f, start_c, stop_c;
	logic [7:0] sh, next_sh, cmd, next_cmd;
	logic [2:0] bits, next_bits;
	logic rw, next_rw, byte_ix, next_byte_ix;
	logic next_power, next_irq, loaded, next_loaded, next_nv_wr, next_nv_wdata;
	logic sda_oe, next_sda_oe;
	function automatic logic [7:0] resp(input logic [7:0] c, input logic ix);
		unique case (c)
			CMD_RD_POWER: resp = {7'h0, power_mode};
			CMD_RD_IRQ: resp = {7'h0, irq_mode};
			CMD_RD_FW: resp = FW_VERSION;
			CMD_RD_ID: resp = ix ? CHIP_ID[7:0] : CHIP_ID[15:8];
			default: resp = 8'hFF;
		endcase
	endfunction
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_s <= 3'b111;
			sda_s <= 3'b111;
		end
		else
		begin
			scl_s <= {scl_s[1:0], link.scl};
			sda_s <= {sda_s[1:0], link.sda};
		end
	end
	assign scl = scl_s[1];
	assign sda = sda_s[1];
	assign scl_r = scl && !scl_s[2];
	assign scl_f = !scl && scl_s[2];
	assign start_c = scl && scl_s[2] && !sda && sda_s[2];
	assign stop_c = scl && scl_s[2] && sda && !sda_s[2];
	always_comb
	begin
		next_st = st;
		next_sh = sh;
		next_cmd = cmd;
		next_bits = bits;
		next_rw = rw;
		next_byte_ix = byte_ix;
		next_power = power_mode;
		next_irq = irq_mode;
		next_loaded = 1'b1;
		next_nv_wr = 1'b0;
		next_nv_wdata = nv_wdata;
		next_sda_oe = sda_oe;
		if (!loaded)
			next_irq = nv_irq_mode;
		if (start_c)
		begin
			next_st = S_ADDR;
			next_bits = 3'h0;
			next_sda_oe = 1'b0;
		end
		else if (stop_c)
		begin
			next_st = S_IDLE;
			next_sda_oe = 1'b0;
		end
		else
			unique case (st)
				S_IDLE, S_SKIP: next_sda_oe = 1'b0;
				S_ADDR, S_CMD, S_DATA:
					if (scl_r)
					begin
						next_sh = {sh[6:0], sda};
						next_bits = bits + 3'h1;
						if (bits == 3'h7)
						begin
							if (st == S_ADDR)
							begin
								next_rw = sda;
								next_byte_ix = 1'b0;
								next_st = (sh[6:0] == SLAVE_ADDR) ? S_AACK : S_SKIP;
							end
							else
								next_st = (st == S_CMD) ? S_CACK : S_DACK;
						end
					end
				S_AACK, S_CACK, S_DACK:
					if (scl_f && !sda_oe)
					begin
						next_sda_oe = 1'b1;
						if (st == S_CACK)
							next_cmd = sh;
						if (st == S_DACK && (sh == MODE_ZERO || sh == MODE_ONE))
						begin
							if (cmd == CMD_WR_POWER)
								next_power = sh[0];
							if (cmd == CMD_WR_IRQ)
							begin
								next_irq = sh[0];
								next_nv_wr = 1'b1;
								next_nv_wdata = sh[0];
							end
						end
					end
					else if (scl_f)
					begin
						next_bits = 3'h0;
						if (st == S_AACK && rw)
						begin
							next_sh = resp(cmd, 1'b0);
							next_st = S_TX;
							next_sda_oe = !next_sh[7];
						end
						else
						begin
							next_sda_oe = 1'b0;
							next_st = (st == S_AACK) ? S_CMD : (st == S_CACK) ? S_DATA : S_SKIP;
						end
					end
				S_TX:
					if (scl_f)
					begin
						next_bits = bits + 3'h1;
						next_sh = {sh[6:0], 1'b0};
						if (bits == 3'h7)
						begin
							next_sda_oe = 1'b0;
							next_st = S_TACK;
						end
						else
							next_sda_oe = !sh[6];
					end
				S_TACK:
					if (scl_r)
					begin
						if (sda)
							next_st = S_SKIP;
						else
						begin
							next_byte_ix = 1'b1;
							next_sh = resp(cmd, 1'b1);
						end
					end
					else if (scl_f)
					begin
						next_bits = 3'h0;
						next_st = S_TX;
						next_sda_oe = !sh[7];
					end
			endcase
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= S_IDLE;
			sh <= 8'h00;
			cmd <= 8'h00;
			bits <= 3'h0;
			rw <= 1'b0;
			byte_ix <= 1'b0;
			power_mode <= 1'b0;
			irq_mode <= 1'b0;
			loaded <= 1'b0;
			nv_wr <= 1'b0;
			nv_wdata <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			st <= next_st;
			sh <= next_sh;
			cmd <= next_cmd;
			bits <= next_bits;
			rw <= next_rw;
			byte_ix <= next_byte_ix;
			power_mode <= next_power;
			irq_mode <= next_irq;
			loaded <= next_loaded;
			nv_wr <= next_nv_wr;
			nv_wdata <= next_nv_wdata;
			sda_oe <= next_sda_oe;
		end
	end
	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe = sda_oe;
	touch_irq_gen #(.REPORT_CYC(REPORT_CYC)) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.pulsed(irq_mode),
		.touch(touch),
		.int_n(link.int_n)
	);
endmodule

// ---- touch_host.sv ----
// host i2c master issuing touch controller commands, apb controlled
//
// Our own choices: register access over APB and the address map.
module touch_host
	import touch_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// link
	touch_link_if.host link
);
	typedef enum {H_IDLE, H_START, H_BIT, H_ACK, H_STOP, H_GAP} hstate_t;
	hstate_t st, next_st;
	logic [1:0] sda_s, int_s;
	logic [7:0] cmd, next_cmd, data, next_data;
	logic [2:0] ctrl, next_ctrl;
	logic [15:0] rd, next_rd;
	logic [2:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic [8:0] sh, next_sh;
	logic [3:0] bitn, next_bitn;
	logic [7:0] gapn, next_gapn;
	logic [1:0] phase, next_phase;
	logic [1:0] byten, next_byten;
	logic [15:0] tick, next_tick;
	logic [1:0] q, next_q;
	logic busy, next_busy, scl_oe, next_scl_oe, sda_oe, next_sda_oe;
	logic [31:0] next_prdata;
	logic next_irq;
	wire wr_acc = psel && penable && pwrite;
	// read data is registered in the setup cycle so it stands through the access cycle
	wire rd_setup = psel && !penable && !pwrite;
	wire tk = (tick == 16'(HALF_SCL - 1));
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sda_s <= 2'b11;
			int_s <= 2'b11;
		end
		else
		begin
			sda_s <= {sda_s[0], link.sda};
			int_s <= {int_s[0], link.int_n};
		end
	end
	always_comb
	begin
		next_st = st;
		next_cmd = cmd;
		next_data = data;
		next_ctrl = ctrl;
		next_rd = rd;
		next_sh = sh;
		next_bitn = bitn;
		next_gapn = gapn;
		next_phase = phase;
		next_byten = byten;
		next_busy = busy;
		next_scl_oe = scl_oe;
		next_sda_oe = sda_oe;
		next_q = q;
		next_tick = tk ? 16'h0 : tick + 16'h1;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_prdata = 32'h0;
		if (!int_s[1])
			next_irq_stat[IRQ_TOUCH] = 1'b1;
		if (wr_acc && paddr == REG_IRQ_STAT)
			next_irq_stat = irq_stat & ~pwdata[2:0] | (int_s[1] ? 3'h0 : 3'h4);
		if (wr_acc && paddr == REG_IRQ_MASK)
			next_irq_mask = pwdata[2:0];
		if (wr_acc && paddr == REG_CMD && !busy)
		begin
			next_cmd = pwdata[7:0];
			next_data = pwdata[15:8];
		end
		if (wr_acc && paddr == REG_CTRL && !busy && pwdata[CTRL_GO])
		begin
			next_ctrl = pwdata[2:0];
			next_busy = 1'b1;
			next_phase = 2'h0;
			next_st = H_START;
			next_q = 2'h0;
		end
		if (rd_setup)
			unique case (paddr)
				REG_CTRL: next_prdata = {29'h0, ctrl};
				REG_CMD: next_prdata = {16'h0, data, cmd};
				REG_STAT: next_prdata = {31'h0, busy};
				REG_RDATA: next_prdata = {16'h0, rd};
				REG_IRQ_STAT: next_prdata = {29'h0, irq_stat};
				REG_IRQ_MASK: next_prdata = {29'h0, irq_mask};
				default: next_prdata = BAD_ADDR_DATA;
			endcase
		if (tk)
			unique case (st)
				H_IDLE:
				begin
					next_scl_oe = 1'b0;
					next_sda_oe = 1'b0;
				end
				H_START:
				begin
					next_q = q + 2'h1;
					if (q == 2'h0)
						next_sda_oe = 1'b1;
					else if (q == 2'h1)
					begin
						next_scl_oe = 1'b1;
						next_byten = 2'h0;
						next_sh = {SLAVE_ADDR, phase == 2'h1, 1'b1};
						next_bitn = 4'h0;
						next_q = 2'h0;
						next_st = H_BIT;
					end
				end
				H_BIT:
				begin
					next_q = q + 2'h1;
					if (q == 2'h0)
						next_sda_oe = !sh[8];
					else if (q == 2'h1)
						next_scl_oe = 1'b0;
					else
					begin
						next_scl_oe = 1'b1;
						next_q = 2'h0;
						next_sh = {sh[7:0], sda_s[1]};
						next_bitn = bitn + 4'h1;
						if (bitn == 4'h8)
						begin
							next_st = H_ACK;
							next_sda_oe = 1'b0;
						end
					end
				end
				H_ACK:
				begin
					next_q = 2'h0;
					next_bitn = 4'h0;
					next_byten = byten + 2'h1;
					if (phase == 2'h1)
					begin
						next_rd = {rd[7:0], sh[8:1]};
						// last byte read is refused with a nack, then stop
						if (byten == 2'h0)
						begin
							next_sh = {8'hFF, !ctrl[CTRL_TWO]};
							next_st = H_BIT;
						end
						else if (byten == 2'h1 && ctrl[CTRL_TWO])
						begin
							next_sh = {8'hFF, 1'b1};
							next_st = H_BIT;
						end
						else
							next_st = H_STOP;
					end
					else if (sh[0])
					begin
						next_irq_stat[IRQ_NACK] = 1'b1;
						next_st = H_STOP;
					end
					else if (byten == 2'h0)
					begin
						next_sh = {cmd, 1'b1};
						next_st = H_BIT;
					end
					else if (byten == 2'h1 && !ctrl[CTRL_READ])
					begin
						next_sh = {data, 1'b1};
						next_st = H_BIT;
					end
					else
						next_st = H_STOP;
				end
				H_STOP:
				begin
					next_q = q + 2'h1;
					if (q == 2'h0)
						next_sda_oe = 1'b1;
					else if (q == 2'h1)
						next_scl_oe = 1'b0;
					else
					begin
						next_sda_oe = 1'b0;
						next_q = 2'h0;
						next_gapn = 8'h00;
						next_st = H_GAP;
					end
				end
				H_GAP:
				begin
					next_gapn = gapn + 8'h01;
					if (gapn == 8'(GAP_CYC / HALF_SCL))
					begin
						if (ctrl[CTRL_READ] && phase == 2'h0 && !irq_stat[IRQ_NACK])
						begin
							next_phase = 2'h1;
							next_st = H_START;
						end
						else
						begin
							next_busy = 1'b0;
							next_irq_stat[IRQ_DONE] = 1'b1;
							next_st = H_IDLE;
						end
					end
				end
			endcase
		next_irq = |(next_irq_stat & next_irq_mask);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= H_IDLE;
			cmd <= 8'h00;
			data <= 8'h00;
			ctrl <= 3'h0;
			rd <= 16'h0;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			sh <= 9'h0;
			bitn <= 4'h0;
			gapn <= 8'h00;
			phase <= 2'h0;
			byten <= 2'h0;
			busy <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			q <= 2'h0;
			tick <= 16'h0;
			prdata <= 32'h0;
			irq <= 1'b0;
		end
		else
		begin
			st <= next_st;
			cmd <= next_cmd;
			data <= next_data;
			ctrl <= next_ctrl;
			rd <= next_rd;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			sh <= next_sh;
			bitn <= next_bitn;
			gapn <= next_gapn;
			phase <= next_phase;
			byten <= next_byten;
			busy <= next_busy;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			q <= next_q;
			tick <= next_tick;
			prdata <= next_prdata;
			irq <= next_irq;
		end
	end
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign link.scl_o = 1'b0;
	assign link.scl_oe = scl_oe;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = sda_oe;
endmodule

// ---- touch_link_props.sv ----
// assertion checker for the touch command link and interrupt pin
module touch_link_props
	import touch_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe,
	input wire logic int_n,
	// device side
	input wire logic touch,
	input wire logic irq_mode,
	input wire logic power_mode,
	input wire logic nv_wr,
	input wire logic nv_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_q;
	logic sda_q;
	logic in_frame;
	int gap_cnt;
	int low_cnt;
	wire logic start = scl && scl_q && sda_q && !sda;
	wire logic stop = scl && scl_q && !sda_q && sda;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			in_frame <= 1'b0;
			gap_cnt <= GAP_CYC;
			low_cnt <= 0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			in_frame <= start || (in_frame && !stop);
			gap_cnt <= stop ? 0 : ((gap_cnt < GAP_CYC) ? gap_cnt + 1 : gap_cnt);
			low_cnt <= int_n ? 0 : low_cnt + 1;
		end
	end
	AST_LEVEL_LOW: assert property ($rose(touch) && !irq_mode |-> ##[1:6] !int_n)
		else $error("level pin not asserted on touch");
	AST_LEVEL_HIGH: assert property ($fell(touch) && !irq_mode |-> ##[1:6] int_n)
		else $error("level pin not released after touch");
	AST_PULSE_START: assert property ($rose(touch) && irq_mode |-> ##[1:6] !int_n)
		else $error("pulse not started on touch");
	AST_PULSE_LEN: assert property ($rose(int_n) && irq_mode && touch |-> low_cnt == PULSE_CYC)
		else $error("pulse length wrong");
	AST_PULSE_MAX: assert property (irq_mode |-> low_cnt <= PULSE_CYC)
		else $error("pulse too long");
	AST_GAP: assert property (start |-> gap_cnt >= GAP_CYC - 1)
		else $error("start too soon after stop");
	AST_NO_RSTART: assert property (start |-> !in_frame)
		else $error("repeated start seen");
	AST_DEV_SDA: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("device moved data while clock high");
	AST_NV_WR: assert property (nv_wr |-> ##[0:2] irq_mode == nv_wdata)
		else $error("stored mode differs from applied mode");
	AST_POWER_CHG: assert property ($changed(power_mode) |-> in_frame || gap_cnt < 50)
		else $error("power mode changed without a write");
endmodule

// ---- touch_ctrl_mode_id_cmds_test.sv ----
// self-checking bench joining host and touch device over the link
module touch_ctrl_mode_id_cmds_test
	import touch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int REPORT = 2000;
	localparam logic [7:0] FW = 8'h3C; // arbitrary
	localparam logic [15:0] CID = 16'hB7E1; // arbitrary
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic touch = 1'b0;
	logic nv_irq_mode = 1'b0;
	logic nv_wr;
	logic nv_wdata;
	logic power_mode;
	logic irq_mode;
	logic [31:0] r;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	touch_link_if link();
	touch_host i_touch_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .link(link.host));
	touch_dev #(.FW_VERSION(FW), .CHIP_ID(CID), .REPORT_CYC(REPORT)) i_touch_dev (.pclk(pclk),
		.presetn(presetn), .touch(touch), .nv_irq_mode(nv_irq_mode), .nv_wr(nv_wr),
		.nv_wdata(nv_wdata), .power_mode(power_mode), .irq_mode(irq_mode), .link(link.dev));
	touch_link_props i_touch_link_props (.pclk(pclk), .presetn(presetn), .scl(link.scl),
		.sda(link.sda), .sda_dev_oe(link.sda_dev_oe), .int_n(link.int_n), .touch(touch),
		.irq_mode(irq_mode), .power_mode(power_mode), .nv_wr(nv_wr), .nv_wdata(nv_wdata));
	initial
		forever #50 pclk = ~pclk;
	// nonvolatile cell survives every reset
	always @(posedge pclk)
		if (nv_wr === 1'b1)
			nv_irq_mode <= nv_wdata;
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic run_cmd(input logic [7:0] c, input logic [7:0] d, input logic [2:0] ctrl);
		logic [31:0] s;
		apb(1'b1, REG_CMD, {16'h0000, d, c}, s);
		apb(1'b1, REG_CTRL, {29'h0000_0000, ctrl}, s);
		s = 32'h0000_0001;
		for (int n = 0; n < 4000 && s[0] !== 1'b0; n++)
			apb(1'b0, REG_STAT, 32'h0000_0000, s);
		apb(1'b0, REG_RDATA, 32'h0000_0000, r);
		apb(1'b0, REG_IRQ_STAT, 32'h0000_0000, s);
		check({s[IRQ_NACK], s[IRQ_DONE]}, 2'b01);
		check({link.scl, link.sda}, 2'b11);
		apb(1'b1, REG_IRQ_STAT, 32'h0000_0003, s);
	endtask
	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	task automatic count_while(input logic v, output int n);
		n = 0;
		while (link.int_n === v && n < 5000)
		begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic t_reset();
		check({link.int_n, irq, power_mode}, 3'b100);
		check(pslverr, 1'b0);
		check(irq_mode, MODE_ZERO[0]);
		apb(1'b0, 8'hFC, 32'h0000_0000, r);
		check(r, BAD_ADDR_DATA);
	endtask
	task automatic t_power();
		// power is read only before any power write, so no settling wait is owed
		run_cmd(CMD_RD_POWER, 8'h00, 3'b011);
		check(r[7:0], MODE_ZERO);
		run_cmd(CMD_WR_POWER, MODE_ONE, 3'b001);
		check(power_mode, 1'b1);
		run_cmd(CMD_WR_POWER, 8'h02, 3'b001);
		check(power_mode, 1'b1);
		run_cmd(CMD_WR_POWER, MODE_ZERO, 3'b001);
		check(power_mode, 1'b0);
	endtask
	task automatic t_level();
		int n;
		logic v1;
		touch <= 1'b1;
		repeat (10) @(posedge pclk);
		count_while(1'b0, n);
		check(n, 5000);
		touch <= 1'b0;
		repeat (10) @(posedge pclk);
		check(link.int_n, 1'b1);
		apb(1'b0, REG_IRQ_STAT, 32'h0000_0000, r);
		check(r[IRQ_TOUCH], 1'b1);
		apb(1'b1, REG_IRQ_MASK, 32'h0000_0007, r);
		v1 = irq;
		apb(1'b1, REG_IRQ_MASK, 32'h0000_0000, r);
		check({v1 ^ irq, v1 | irq}, 2'b11);
		apb(1'b1, REG_IRQ_STAT, 32'h0000_0007, r);
		apb(1'b0, REG_IRQ_STAT, 32'h0000_0000, r);
		check(r[IRQ_TOUCH], 1'b0);
		check(irq, 1'b0);
	endtask
	task automatic t_irq_mode();
		run_cmd(CMD_RD_IRQ, 8'h00, 3'b011);
		check(r[7:0], MODE_ZERO);
		run_cmd(CMD_WR_IRQ, MODE_ONE, 3'b001);
		check({irq_mode, nv_irq_mode}, 2'b11);
		run_cmd(CMD_RD_IRQ, 8'h00, 3'b011);
		check(r[7:0], MODE_ONE);
		run_cmd(CMD_WR_IRQ, 8'h7F, 3'b001);
		check(irq_mode, 1'b1);
	endtask
	task automatic t_pulse();
		int lo;
		int hi;
		touch <= 1'b1;
		count_while(1'b1, hi);
		count_while(1'b0, lo);
		count_while(1'b1, hi);
		check(lo, PULSE_CYC);
		check(lo + hi, REPORT);
		touch <= 1'b0;
		repeat (PULSE_CYC + 10) @(posedge pclk);
		count_while(1'b1, hi);
		check(hi, 5000);
	endtask
	task automatic t_persist();
		reset_dut();
		check(irq_mode, 1'b1);
		run_cmd(CMD_WR_IRQ, MODE_ZERO, 3'b001);
		reset_dut();
		check(irq_mode, 1'b0);
	endtask
	task automatic t_ident();
		run_cmd(CMD_RD_FW, 8'h00, 3'b011);
		check(r[7:0], FW);
		run_cmd(CMD_RD_ID, 8'h00, 3'b111);
		check(r[15:0], CID);
	endtask
	initial
	begin
		reset_dut();
		t_reset();
		t_power();
		t_level();
		t_irq_mode();
		t_pulse();
		t_persist();
		t_ident();
		complete_run();
	end
endmodule
